/* verilog/psrb_regs.svh */
// Port map, field positions, widths and reset values of the port status bank
`ifndef PSRB_REGS_SVH
`define PSRB_REGS_SVH

// =====================================================================
// Port map: bit 0 is the summary slot, 1..9 module ports, 10..13 serial
`define PSRB_NPORT       13
`define PSRB_NMOD        9
`define PSRB_SUM_BIT     0
`define PSRB_PORT_W      4

// =====================================================================
// Reset values
`define PSRB_EN_RST      14'h0000
`define PSRB_EV_RST      14'h0000
// Open serial lines idle high, open module lines low
`define PSRB_CTS_RST     14'h3c00

`endif

/* verilog/psrb_pkg.sv */
// Types shared by the port status register bank
package psrb_pkg;

    // =================================================================
    // Query or set operation
    typedef enum logic
    {
        PSRB_OP_READ,
        PSRB_OP_WRITE
    } psrb_op_t;

    // =================================================================
    // Register selected by a command
    typedef enum logic [3:0]
    {
        PSRB_SEL_TO_EV,
        PSRB_SEL_TO_EN,
        PSRB_SEL_OV_EV,
        PSRB_SEL_OV_EN,
        PSRB_SEL_FC_EV,
        PSRB_SEL_FC_EN,
        PSRB_SEL_CTS_COND,
        PSRB_SEL_CTS_EV,
        PSRB_SEL_CTS_EN,
        PSRB_SEL_CE_EV
    } psrb_sel_t;

endpackage : psrb_pkg

/* verilog/psrb_port_status.sv */
// Per-port event, enable and clear-to-send status register bank
//
// Contract
// - Timeout events, read whole or one port
// - Timeout read clears exactly the returned bits
// - Timeout enable writable and readable, whole or bit
// - Overflow events, read whole or bit, cleared
// - Overflow enable writable and readable, whole or bit
// - Flow read clears bits except cts summary
// - Flow enable writable and readable, whole or bit
// - Cts condition is live, never latched
// - Unconnected module port cts reads zero
// - Unconnected serial port cts reads one
// - Cts event register cleared by its read
// - Comm error read keeps timeout summary bit
// - Cts enable writable and readable, whole or bit
`include "psrb_regs.svh"

module psrb_port_status
    import psrb_pkg::*;
#(
    parameter int NPORT = `PSRB_NPORT,   // Highest port number
    parameter int NMOD  = `PSRB_NMOD     // Ports 1..NMOD are module ports
)
(
    input  wire logic                 ref_clk,        // 100 MHz clock
    input  wire logic                 reset_n,        // Async reset
    input  wire logic                 cmd_valid,      // Command strobe
    input  wire psrb_op_t             cmd_op,         // Query or set
    input  wire psrb_sel_t            cmd_sel,        // Register chosen
    input  wire logic                 cmd_port_valid, // Port argument given
    input  wire logic [`PSRB_PORT_W-1:0] cmd_port,    // Port number
    input  wire logic [NPORT:0]       cmd_wdata,      // Write value
    input  wire logic [NPORT:1]       timeout_evt,    // Timeout pulses
    input  wire logic [NPORT:1]       overflow_evt,   // Overflow pulses
    input  wire logic [NPORT:1]       flowctl_evt,    // Flow-control pulses
    input  wire logic [NPORT:1]       comm_err_evt,   // Comm error pulses
    input  wire logic [NPORT:1]       cts_pin,        // Cts level when driven
    input  wire logic [NPORT:1]       cts_driven,     // Far end drives cts
    output logic                      rsp_valid_q,    // Answer strobe
    output logic [NPORT:0]            rsp_data_q,     // Answer value
    output logic                      rsp_err_q,      // Bad command
    output logic                      timeout_summary_bit_q, // Timeout sum
    output logic                      overflow_summary_q,    // Overflow sum
    output logic                      flowctl_summary_q,     // Flow sum
    output logic                      cts_summary_bit_q      // Cts sum
);

    localparam int W = NPORT + 1;

    // =================================================================
    // Decoding helpers
    // One-hot mask for a port argument, ones on ports 1..NPORT without one
    function automatic logic [NPORT:0] psrb_mask(
        input logic                    pv,
        input logic [`PSRB_PORT_W-1:0] p
    );
        logic [NPORT:0] m;
        m = '0;
        for (int i = 1; i <= NPORT; i++)
        begin
            if (!pv || p == i[`PSRB_PORT_W-1:0])
            begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : psrb_mask

    // New enable value after a whole or single-bit write
    function automatic logic [NPORT:0] psrb_wr(
        input logic [NPORT:0] old,
        input logic [NPORT:0] m,
        input logic           pv,
        input logic [NPORT:0] wd
    );
        logic [NPORT:0] v;
        v = pv ? ((old & ~m) | (m & {W{wd[0]}})) : (wd & m);
        return v;
    endfunction : psrb_wr

    // =================================================================
    // State
    logic [NPORT:0] timeout_ev_q, overflow_ev_q, flowctl_ev_q;
    logic [NPORT:0] cts_ev_q, comm_err_q;
    logic [NPORT:0] timeout_en_q, overflow_en_q, flowctl_en_q, cts_en_q;
    logic [NPORT:0] cts_prev_q;

    // =================================================================
    // Command decode
    wire            port_ok = !cmd_port_valid ||
                              (cmd_port >= 1 && cmd_port <= NPORT);
    wire            rd      = cmd_valid && cmd_op == PSRB_OP_READ && port_ok;
    wire            wr      = cmd_valid && cmd_op == PSRB_OP_WRITE && port_ok;
    wire [NPORT:0]  oh      = psrb_mask(cmd_port_valid, cmd_port);
    wire            wr_en   = cmd_sel == PSRB_SEL_TO_EN  ||
                              cmd_sel == PSRB_SEL_OV_EN  ||
                              cmd_sel == PSRB_SEL_FC_EN  ||
                              cmd_sel == PSRB_SEL_CTS_EN;
    wire            bad     = cmd_valid && (!port_ok || (wr && !wr_en) ||
                              cmd_sel > PSRB_SEL_CE_EV);

    // =================================================================
    // Pin resolution: pulls apply where the far end leaves cts open
    wire [NPORT:0]  cts_eff;
    assign cts_eff[`PSRB_SUM_BIT] = 1'b0;
    genvar g;
    generate
        for (g = 1; g <= NPORT; g++)
        begin : g_cts
            if (g <= NMOD)
            begin : g_mod
                assign cts_eff[g] = cts_driven[g] & cts_pin[g];
            end
            else
            begin : g_ser
                assign cts_eff[g] = !cts_driven[g] | cts_pin[g];
            end
        end
    endgenerate

    // =================================================================
    // Clear masks: a read clears only what it returns; summary slot
    // bit 0 is never stored, so it survives every read
    wire [NPORT:0]  to_clr  = (rd && cmd_sel == PSRB_SEL_TO_EV) ? oh : '0;
    wire [NPORT:0]  ov_clr  = (rd && cmd_sel == PSRB_SEL_OV_EV) ? oh : '0;
    wire [NPORT:0]  fc_clr  = (rd && cmd_sel == PSRB_SEL_FC_EV) ? oh : '0;
    wire [NPORT:0]  cts_clr = (rd && cmd_sel == PSRB_SEL_CTS_EV) ? oh : '0;
    wire [NPORT:0]  ce_clr  = (rd && cmd_sel == PSRB_SEL_CE_EV) ? oh : '0;

    // Set wins over clear so an event in the read cycle is kept
    wire [NPORT:0]  cts_set = cts_eff ^ cts_prev_q;
    wire [NPORT:0]  to_d    = (timeout_ev_q & ~to_clr) | {timeout_evt, 1'b0};
    wire [NPORT:0]  ov_d    = (overflow_ev_q & ~ov_clr) | {overflow_evt,1'b0};
    wire [NPORT:0]  fc_d    = (flowctl_ev_q & ~fc_clr) | {flowctl_evt, 1'b0};
    wire [NPORT:0]  cts_d   = (cts_ev_q & ~cts_clr) | cts_set;
    wire [NPORT:0]  ce_d    = (comm_err_q & ~ce_clr) | {comm_err_evt, 1'b0};

    // =================================================================
    // Summaries from latched events gated by enables
    wire            to_sum  = |(timeout_ev_q & timeout_en_q);
    wire            ov_sum  = |(overflow_ev_q & overflow_en_q);
    wire            fc_sum  = |(flowctl_ev_q & flowctl_en_q);
    wire            cts_sum = |(cts_ev_q & cts_en_q);

    // =================================================================
    // Read selection; summary bits sit in bit 0 of their owners
    wire [NPORT:0]  sel_val =
        cmd_sel == PSRB_SEL_TO_EV    ? timeout_ev_q :
        cmd_sel == PSRB_SEL_TO_EN    ? timeout_en_q :
        cmd_sel == PSRB_SEL_OV_EV    ? overflow_ev_q :
        cmd_sel == PSRB_SEL_OV_EN    ? overflow_en_q :
        cmd_sel == PSRB_SEL_FC_EV    ? (flowctl_ev_q | W'(cts_sum)) :
        cmd_sel == PSRB_SEL_FC_EN    ? flowctl_en_q :
        cmd_sel == PSRB_SEL_CTS_COND ? cts_eff :
        cmd_sel == PSRB_SEL_CTS_EV   ? cts_ev_q :
        cmd_sel == PSRB_SEL_CTS_EN   ? cts_en_q :
        cmd_sel == PSRB_SEL_CE_EV    ? (comm_err_q | W'(to_sum)) :
                                       '0;
    wire [NPORT:0]  rd_val  = cmd_port_valid ? W'(|(sel_val & oh)) : sel_val;

    // =================================================================
    // Enable writes
    wire            we_to   = wr && cmd_sel == PSRB_SEL_TO_EN;
    wire            we_ov   = wr && cmd_sel == PSRB_SEL_OV_EN;
    wire            we_fc   = wr && cmd_sel == PSRB_SEL_FC_EN;
    wire            we_cts  = wr && cmd_sel == PSRB_SEL_CTS_EN;

    // =================================================================
    // Event registers; cts_prev starts at the pull levels of open pins
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            timeout_ev_q  <= `PSRB_EV_RST;
            overflow_ev_q <= `PSRB_EV_RST;
            flowctl_ev_q  <= `PSRB_EV_RST;
            cts_ev_q      <= `PSRB_EV_RST;
            comm_err_q    <= `PSRB_EV_RST;
            cts_prev_q    <= `PSRB_CTS_RST;
        end
        else
        begin
            timeout_ev_q  <= to_d;
            overflow_ev_q <= ov_d;
            flowctl_ev_q  <= fc_d;
            cts_ev_q      <= cts_d;
            comm_err_q    <= ce_d;
            cts_prev_q    <= cts_eff;
        end
    end

    // Enable registers
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            timeout_en_q  <= `PSRB_EN_RST;
            overflow_en_q <= `PSRB_EN_RST;
            flowctl_en_q  <= `PSRB_EN_RST;
            cts_en_q      <= `PSRB_EN_RST;
        end
        else
        begin
            if (we_to)
                timeout_en_q <= psrb_wr(timeout_en_q, oh, cmd_port_valid,
                                        cmd_wdata);
            if (we_ov)
                overflow_en_q <= psrb_wr(overflow_en_q, oh, cmd_port_valid,
                                         cmd_wdata);
            if (we_fc)
                flowctl_en_q <= psrb_wr(flowctl_en_q, oh, cmd_port_valid,
                                        cmd_wdata);
            if (we_cts)
                cts_en_q <= psrb_wr(cts_en_q, oh, cmd_port_valid,
                                    cmd_wdata);
        end
    end

    // Answer and summary outputs, all registered
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rsp_valid_q           <= 1'b0;
            rsp_data_q            <= '0;
            rsp_err_q             <= 1'b0;
            timeout_summary_bit_q <= 1'b0;
            overflow_summary_q    <= 1'b0;
            flowctl_summary_q     <= 1'b0;
            cts_summary_bit_q     <= 1'b0;
        end
        else
        begin
            rsp_valid_q           <= cmd_valid;
            rsp_data_q            <= rd ? rd_val : '0;
            rsp_err_q             <= bad;
            timeout_summary_bit_q <= to_sum;
            overflow_summary_q    <= ov_sum;
            flowctl_summary_q     <= fc_sum;
            cts_summary_bit_q     <= cts_sum;
        end
    end

    // =================================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence full_read_s(psrb_sel_t s);
        rd && !cmd_port_valid && cmd_sel == s;
    endsequence

    to_read_clear_a: assert property (
        full_read_s(PSRB_SEL_TO_EV) ##0 (timeout_evt == '0)
        |=> timeout_ev_q == '0)
        else $error("timeout events survived a full read");
    ov_bit_clear_a: assert property (
        rd && cmd_port_valid && cmd_sel == PSRB_SEL_OV_EV &&
        overflow_evt == '0
        |=> overflow_ev_q == ($past(overflow_ev_q) & ~$past(oh)))
        else $error("overflow bit read cleared wrong bits");
    to_latch_a: assert property (
        to_clr == '0 |=> (timeout_ev_q & $past(timeout_ev_q)) ==
                         $past(timeout_ev_q))
        else $error("timeout event lost without a read");
    to_en_write_a: assert property (
        wr && !cmd_port_valid && cmd_sel == PSRB_SEL_TO_EN
        |=> timeout_en_q == ($past(cmd_wdata) & ~W'(1)))
        else $error("timeout enable write not stored");
    cts_live_a: assert property (
        full_read_s(PSRB_SEL_CTS_COND) |=> rsp_data_q == $past(cts_eff))
        else $error("cts condition not the present level");
    mod_pull_a: assert property (
        !cts_driven[1] |-> !cts_eff[1])
        else $error("open module port cts not low");
    ser_pull_a: assert property (
        !cts_driven[NPORT] |-> cts_eff[NPORT])
        else $error("open serial port cts not high");
    fc_keep_sum_a: assert property (
        full_read_s(PSRB_SEL_FC_EV) |=> rsp_data_q[0] == $past(cts_sum))
        else $error("flow read lost the cts summary");
    ce_sum_a: assert property (
        full_read_s(PSRB_SEL_CE_EV) and to_sum
        |=> rsp_data_q[0] ##1 timeout_summary_bit_q)
        else $error("comm error read dropped timeout summary");
    cts_edge_a: assert property (
        cts_set[1] |=> cts_ev_q[1])
        else $error("cts change not latched");
    rsp_time_a: assert property (
        cmd_valid |=> rsp_valid_q ##1 (rsp_valid_q == $past(cmd_valid)))
        else $error("answer not one cycle after command");

endmodule : psrb_port_status

/* test/psrb_port_model.sv */
// Far-side model of the ports: plugged modules and serial remote devices
module psrb_port_model
(
    input  wire logic        ref_clk,    // Bench clock
    input  wire logic        reset_n,    // Async reset
    input  wire logic [9:1]  plugged,    // Module present per port
    input  wire logic [4:1]  hold,       // Remote holds off serial port
    output logic      [13:1] cts_pin,    // Cts level when driven
    output logic      [13:1] cts_driven  // Far end drives cts
);
    timeunit 1ns;
    timeprecision 1ns;

    // =========================================================
    // Driven levels and release behaviour
    logic        flip_q;
    logic [13:1] level;

    // Released lines toggle so a stale level never reads as valid
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            flip_q <= 1'b0;
        else
            flip_q <= ~flip_q;
    end

    // Plugged modules drive high, a holding remote drives low
    assign level      = {4'h0, 9'h1ff};
    assign cts_driven = {hold, plugged};
    assign cts_pin    = (cts_driven & level)
                      | (~cts_driven & {13{flip_q}});
endmodule : psrb_port_model

/* test/test_port_status_register_bank.sv */
// Self-checking bench for the port status register bank
module test_port_status_register_bank;
    import psrb_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // =========================================================
    // Signals
    logic ref_clk, reset_n, cmd_valid, cmd_port_valid, got_err;
    logic rsp_valid_q, rsp_err_q, to_sum, ov_sum, fc_sum, cts_sum;
    psrb_op_t    cmd_op;
    psrb_sel_t   cmd_sel;
    logic [3:0]  cmd_port;
    logic [13:0] cmd_wdata, rsp_data_q, got;
    logic [13:1] to_e, ov_e, fc_e, ce_e, cts_pin, cts_driven;
    logic [9:1]  plugged;
    logic [4:1]  hold;
    int          err_total, total_checks, cycles;
    psrb_sel_t   ev_sel [3] = '{PSRB_SEL_TO_EV, PSRB_SEL_OV_EV,
                                PSRB_SEL_FC_EV};
    psrb_sel_t   en_sel [4] = '{PSRB_SEL_TO_EN, PSRB_SEL_OV_EN,
                                PSRB_SEL_FC_EN, PSRB_SEL_CTS_EN};

    psrb_port_status uut (.ref_clk(ref_clk), .reset_n(reset_n),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_sel(cmd_sel),
        .cmd_port_valid(cmd_port_valid), .cmd_port(cmd_port),
        .cmd_wdata(cmd_wdata), .timeout_evt(to_e), .overflow_evt(ov_e),
        .flowctl_evt(fc_e), .comm_err_evt(ce_e), .cts_pin(cts_pin),
        .cts_driven(cts_driven), .rsp_valid_q(rsp_valid_q),
        .rsp_data_q(rsp_data_q), .rsp_err_q(rsp_err_q),
        .timeout_summary_bit_q(to_sum), .overflow_summary_q(ov_sum),
        .flowctl_summary_q(fc_sum), .cts_summary_bit_q(cts_sum));

    psrb_port_model far_end (.ref_clk(ref_clk), .reset_n(reset_n),
        .plugged(plugged), .hold(hold), .cts_pin(cts_pin),
        .cts_driven(cts_driven));

    // =========================================================
    // Clock and hang guard
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Whole run needs about 150 cycles; the ceiling is generous
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            complete_run();
        end
    end

    // =========================================================
    // Compare, command and stimulus tasks
    task automatic chk_data(input string n, input logic [13:0] e,
                            input logic [13:0] s);
        total_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk_data

    task automatic chk_bit(input string n, input logic e, input logic s);
        total_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("ERROR %s expected %b seen %b", n, e, s);
        end
    endtask : chk_bit

    // One command, answer captured the cycle after it is taken
    task automatic cmd(input psrb_op_t op, input psrb_sel_t sel,
                       input logic pv, input logic [3:0] p,
                       input logic [13:0] wd);
        @(posedge ref_clk);
        cmd_valid      <= 1'b1;
        cmd_op         <= op;
        cmd_sel        <= sel;
        cmd_port_valid <= pv;
        cmd_port       <= p;
        cmd_wdata      <= wd;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        #1;
        chk_bit("rsp_valid_q", 1'b1, rsp_valid_q);
        got     = rsp_data_q;
        got_err = rsp_err_q;
    endtask : cmd

    task automatic wr(input psrb_sel_t sel, input logic pv,
                      input logic [3:0] p, input logic [13:0] wd);
        cmd(PSRB_OP_WRITE, sel, pv, p, wd);
    endtask : wr

    task automatic rdc(input psrb_sel_t sel, input logic pv,
                       input logic [3:0] p, input logic [13:0] e);
        cmd(PSRB_OP_READ, sel, pv, p, 14'h0000);
        chk_data("rsp_data_q", e, got);
        chk_bit("rsp_err_q", 1'b0, got_err);
    endtask : rdc

    // One-cycle event pulse on source k: timeout, overflow, flow, comm
    task automatic pulse(input int k, input logic [13:0] m);
        @(posedge ref_clk);
        case (k)
            0: to_e <= m[13:1];
            1: ov_e <= m[13:1];
            2: fc_e <= m[13:1];
            default: ce_e <= m[13:1];
        endcase
        @(posedge ref_clk);
        {to_e, ov_e, fc_e, ce_e} <= '0;
    endtask : pulse

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : settle

    task automatic complete_run();
        if (err_total == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    // =========================================================
    // Test sequence
    initial
    begin
        {reset_n, cmd_valid, cmd_port_valid, cmd_port, cmd_wdata} = '0;
        {to_e, ov_e, fc_e, ce_e, plugged, hold} = '0;
        {err_total, total_checks, cycles} = '0;
        cmd_op  = PSRB_OP_READ;
        cmd_sel = PSRB_SEL_TO_EV;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        settle(2);
        // Open lines rest at their pull levels: no event after reset
        rdc(PSRB_SEL_CTS_EV, 1'b0, 4'h0, 14'h0000);
        rdc(PSRB_SEL_CTS_EV, 1'b0, 4'h0, 14'h0000);
        rdc(PSRB_SEL_CTS_COND, 1'b0, 4'h0, 14'h3c00);
        @(posedge ref_clk);
        plugged <= 9'h008;
        hold    <= 4'h2;
        rdc(PSRB_SEL_CTS_COND, 1'b0, 4'h0, 14'h3410);
        rdc(PSRB_SEL_CTS_COND, 1'b1, 4'h4, 14'h0001);
        rdc(PSRB_SEL_CTS_COND, 1'b1, 4'hb, 14'h0000);
        rdc(PSRB_SEL_CTS_EV, 1'b1, 4'h4, 14'h0001);
        rdc(PSRB_SEL_CTS_EV, 1'b0, 4'h0, 14'h0800);
        // Port read clears only its own bit, whole read the rest
        for (int k = 0; k < 3; k++)
        begin
            pulse(k, 14'h0028);
            rdc(ev_sel[k], 1'b1, 4'h3, 14'h0001);
            rdc(ev_sel[k], 1'b0, 4'h0, 14'h0020);
            rdc(ev_sel[k], 1'b0, 4'h0, 14'h0000);
        end
        // Enables: whole write, single-bit write, single-bit read
        for (int i = 0; i < 4; i++)
        begin
            wr(en_sel[i], 1'b0, 4'h0, 14'h1234);
            rdc(en_sel[i], 1'b0, 4'h0, 14'h1234);
            wr(en_sel[i], 1'b1, 4'h4, 14'h0000);
            rdc(en_sel[i], 1'b0, 4'h0, 14'h1224);
            rdc(en_sel[i], 1'b1, 4'h2, 14'h0001);
            wr(en_sel[i], 1'b0, 4'h0, 14'h0000);
        end
        // Timeout summary survives comm error reads until cleared
        wr(PSRB_SEL_TO_EN, 1'b1, 4'h5, 14'h0001);
        pulse(0, 14'h0020);
        pulse(3, 14'h0080);
        settle(3);
        chk_bit("timeout_summary_bit_q", 1'b1, to_sum);
        rdc(PSRB_SEL_CE_EV, 1'b0, 4'h0, 14'h0081);
        rdc(PSRB_SEL_CE_EV, 1'b0, 4'h0, 14'h0001);
        rdc(PSRB_SEL_TO_EV, 1'b0, 4'h0, 14'h0020);
        settle(3);
        chk_bit("timeout_summary_bit_q", 1'b0, to_sum);
        // Cts summary survives flow reads, falls on cts event read
        wr(PSRB_SEL_CTS_EN, 1'b1, 4'h9, 14'h0001);
        @(posedge ref_clk);
        plugged <= 9'h108;
        settle(3);
        chk_bit("cts_summary_bit_q", 1'b1, cts_sum);
        rdc(PSRB_SEL_FC_EV, 1'b0, 4'h0, 14'h0001);
        rdc(PSRB_SEL_FC_EV, 1'b0, 4'h0, 14'h0001);
        rdc(PSRB_SEL_CTS_EV, 1'b0, 4'h0, 14'h0200);
        settle(3);
        chk_bit("cts_summary_bit_q", 1'b0, cts_sum);
        // Overflow and flow summaries from enabled events
        wr(PSRB_SEL_OV_EN, 1'b0, 4'h0, 14'h0004);
        wr(PSRB_SEL_FC_EN, 1'b0, 4'h0, 14'h2000);
        pulse(1, 14'h0004);
        pulse(2, 14'h2000);
        settle(3);
        chk_bit("overflow_summary_q", 1'b1, ov_sum);
        chk_bit("flowctl_summary_q", 1'b1, fc_sum);
        // Refused commands change nothing
        wr(PSRB_SEL_OV_EV, 1'b0, 4'h0, 14'h0000);
        chk_bit("rsp_err_q", 1'b1, got_err);
        cmd(PSRB_OP_READ, PSRB_SEL_OV_EV, 1'b1, 4'he, 14'h0000);
        chk_bit("rsp_err_q", 1'b1, got_err);
        rdc(PSRB_SEL_OV_EV, 1'b0, 4'h0, 14'h0004);
        complete_run();
    end
endmodule : test_port_status_register_bank
